// >>> common/mirq_consts.svh
// Constants of the interrupt and timer request block
`ifndef MIRQ_CONSTS_SVH
`define MIRQ_CONSTS_SVH
`define MIRQ_ADDR_TIMER_COUNT   8'h08
`define MIRQ_ADDR_TIMER_CTRL    8'h09
`define MIRQ_ADDR_MISC          8'h0a
`define MIRQ_ADDR_SERIAL_STAT   8'h11
`define MIRQ_ADDR_CORE_STAT     8'h20
`define MIRQ_BIT_REQ            7
`define MIRQ_BIT_MASK6          6
`define MIRQ_BIT_SER_MASK       5
`define MIRQ_BIT_T2_MASK        4
`define MIRQ_BIT_SER_REQ        7
`define MIRQ_BIT_T2_REQ         6
`define MIRQ_BIT_TSRC_HI        5
`define MIRQ_BIT_TSRC_LO        4
`define MIRQ_BIT_PRESC_INIT     3
`define MIRQ_TIMER_RESET        8'hff
`define MIRQ_PRESC_RESET        7'h7f
`define MIRQ_TCTRL_RESET        8'h50
`define MIRQ_MISC_RESET         8'h40
`define MIRQ_SSTAT_RESET        8'h30
`define MIRQ_VEC_RESET          14'h1ffe
`define MIRQ_VEC_SOFT           14'h1ffc
`define MIRQ_VEC_EXTA           14'h1ffa
`define MIRQ_VEC_TIMER          14'h1ff8
`define MIRQ_VEC_SERIAL         14'h1ff6
`define MIRQ_SP_TOP             14'h00ff
`define MIRQ_SP_LIMIT           14'h00c1
`define MIRQ_ECLK_DIV           2'h3
`endif

// >>> common/mirq_pkg.sv
// Types of the interrupt and timer request block
`default_nettype none
package mirq_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h0,
        SEQ_PUSH = 3'h1,
        SEQ_VECT = 3'h3,
        SEQ_PULL = 3'h2
    } mirq_seq_t;
    typedef enum logic [2:0] {
        SRC_NONE   = 3'h0,
        SRC_RESET  = 3'h1,
        SRC_SOFT   = 3'h2,
        SRC_EXTA   = 3'h3,
        SRC_TIMER  = 3'h4,
        SRC_SERIAL = 3'h5
    } mirq_src_t;
endpackage : mirq_pkg
`default_nettype wire

// >>> rtl/mirq_request_logic.sv
// Interrupt request, priority, vector, stack and timer logic of the microcomputer
//
// Operation
// - Six sources: two pins, timer, second timer, serial, software interrupt.
// - Fixed priority reset, soft, pin A, timer/pin B, serial/second_timer; top vectors.
// - Pin B shares timer vector; second timer shares serial vector.
// - Accept: stack state, set core mask flag, load vector.
// - Push PC low, PC high, index, accumulator, codes; pointer down each push.
// - Return instruction pulls saved state and resumes after interrupted point.
// - Stack pointer top on reset or reset instruction, down push, up pull.
// - Core mask blocks all but soft interrupt; requests stay latched.
// - Held requests served once mask clears, by fixed priority.
// - Both pins falling-edge sensitive, request latched until cleared.
// - Pin A request clears when core vectors into its routine.
// - Pin B flag set by falling edge, cleared by writing zero only.
// - Individual masks: misc bit6, timer ctrl bit6, serial bits 5 and 4.
// - Pin level branches read pin level without touching edge logic.
// - Reset clears pin B flag and sets pin B mask.
// - Timer count loadable, counts down; zero sets timer request bit 7.
// - Counting continues from all ones; reading does not disturb count.
// - Timer clock from timer pin or E clock, E optionally pin-gated.
// - Reset loads prescaler and counter all ones, clears flag, sets mask.
// - Timer request clears only by writing zero.
`include "mirq_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module mirq_request_logic (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output var  logic [7:0]  regRdData_q,
    // Pins
    input  wire logic        extIrqPinA_n,
    input  wire logic        extIrqPinB_n,
    input  wire logic        timerPin,
    // Serial and second timer events
    input  wire logic        serialDone,
    input  wire logic        secondTimerTick,
    // Core sequencer
    input  wire logic        coreBoundary,
    input  wire logic        softIrqInstr,
    input  wire logic        irqReturnInstr,
    input  wire logic        clearMaskInstr,
    input  wire logic        setMaskInstr,
    input  wire logic        stackResetInstr,
    input  wire logic        subCallInstr,
    input  wire logic        subReturnInstr,
    input  wire logic [13:0] corePc,
    input  wire logic [7:0]  coreIndex,
    input  wire logic [7:0]  coreAcc,
    input  wire logic [4:0]  coreCodes,
    // Core outputs
    output var  logic        irqPending_q,
    output var  logic        vectorLoad_q,
    output var  logic [13:0] vectorAddr_q,
    output var  logic        stackWrite_q,
    output var  logic        stackRead_q,
    output var  logic [13:0] stackAddr_q,
    output var  logic [7:0]  stackWrData_q,
    output var  logic        coreMask_q,
    output var  logic        seqBusy_q,
    output var  logic        pinALevel_q,
    output var  logic        pinBLevel_q
);
    // Pin synchronisers
    logic [1:0] pinASync_q;
    logic [1:0] pinBSync_q;
    logic [1:0] tmrSync_q;
    logic       pinAOld_q;
    logic       pinBOld_q;
    logic       tmrOld_q;
    // Interrupt state
    logic       reqA_q;
    logic       reqSoft_q;
    logic [7:0] misc_q;
    logic [7:0] tctrl_q;
    logic [7:0] sstat_q;
    logic [7:0] count_q;
    logic [6:0] presc_q;
    logic [1:0] eDiv_q;
    logic       maskDelay_q;
    logic       coreMaskEff_q;
    logic [13:0] sp_q;
    logic [2:0] stepCnt_q;
    logic       pullMode_q;
    logic [4:0] pushLen_q;
    mirq_pkg::mirq_seq_t seq_q;
    mirq_pkg::mirq_src_t src_q;
    logic [13:0] savePc_q;
    logic [7:0]  saveX_q;
    logic [7:0]  saveA_q;
    logic [4:0]  saveCc_q;

    // Decoding of register accesses
    wire wrCount  = regWrStb && (regAddr == `MIRQ_ADDR_TIMER_COUNT);
    wire wrTctrl  = regWrStb && (regAddr == `MIRQ_ADDR_TIMER_CTRL);
    wire wrMisc   = regWrStb && (regAddr == `MIRQ_ADDR_MISC);
    wire wrSstat  = regWrStb && (regAddr == `MIRQ_ADDR_SERIAL_STAT);
    // Edge detection on second flip-flops only
    wire fallA    = pinAOld_q && !pinASync_q[1];
    wire fallB    = pinBOld_q && !pinBSync_q[1];
    wire tmrFall  = tmrOld_q && !tmrSync_q[1];
    // Timer clock selection
    wire eTick    = (eDiv_q == `MIRQ_ECLK_DIV);
    wire [1:0] tsrc = {tctrl_q[`MIRQ_BIT_TSRC_HI], tctrl_q[`MIRQ_BIT_TSRC_LO]};
    wire tmrClk   = (tsrc == 2'h0) ? eTick :
                    (tsrc == 2'h1) ? (eTick && tmrSync_q[1]) :
                    (tsrc == 2'h3) ? tmrFall : 1'b0;
    wire [2:0] divSel = tctrl_q[2:0];
    wire [6:0] divMask = 7'((8'h01 << divSel) - 8'h01);
    wire prescInit = wrTctrl && regWrData[`MIRQ_BIT_PRESC_INIT];
    wire countTick = tmrClk && ((presc_q & divMask) == 7'h00);
    wire [7:0] countNext = count_q - 8'h01;
    wire timerZero = countTick && (countNext == 8'h00);
    // Gated requests
    wire gateB   = misc_q[`MIRQ_BIT_REQ] && !misc_q[`MIRQ_BIT_MASK6];
    wire gateT   = tctrl_q[`MIRQ_BIT_REQ] && !tctrl_q[`MIRQ_BIT_MASK6];
    wire gateS   = sstat_q[`MIRQ_BIT_SER_REQ] && !sstat_q[`MIRQ_BIT_SER_MASK];
    wire gateT2  = sstat_q[`MIRQ_BIT_T2_REQ] && !sstat_q[`MIRQ_BIT_T2_MASK];
    wire maskOn  = coreMaskEff_q;
    wire hwReq   = !maskOn && (reqA_q || gateB || gateT || gateS || gateT2);
    wire anyReq  = reqSoft_q || hwReq;
    // Fixed priority selection
    wire mirq_pkg::mirq_src_t pick =
        reqSoft_q                  ? mirq_pkg::SRC_SOFT :
        (!maskOn && reqA_q)        ? mirq_pkg::SRC_EXTA :
        (!maskOn && (gateT||gateB))? mirq_pkg::SRC_TIMER :
        (!maskOn && (gateS||gateT2))? mirq_pkg::SRC_SERIAL : mirq_pkg::SRC_NONE;
    wire [13:0] pickVec =
        (src_q == mirq_pkg::SRC_SOFT)  ? `MIRQ_VEC_SOFT :
        (src_q == mirq_pkg::SRC_EXTA)  ? `MIRQ_VEC_EXTA :
        (src_q == mirq_pkg::SRC_TIMER) ? `MIRQ_VEC_TIMER :
        (src_q == mirq_pkg::SRC_SERIAL)? `MIRQ_VEC_SERIAL : `MIRQ_VEC_RESET;
    // Stacked byte for the current step
    wire [7:0] pushByte =
        (stepCnt_q == 3'h0) ? savePc_q[7:0] :
        (stepCnt_q == 3'h1) ? {2'h0, savePc_q[13:8]} :
        (stepCnt_q == 3'h2) ? saveX_q :
        (stepCnt_q == 3'h3) ? saveA_q : {3'h7, saveCc_q};
    wire [13:0] spDown = (sp_q == `MIRQ_SP_LIMIT) ? `MIRQ_SP_TOP : sp_q - 14'h0001;
    wire [13:0] spUp   = (sp_q == `MIRQ_SP_TOP) ? `MIRQ_SP_LIMIT : sp_q + 14'h0001;
    wire [2:0]  lastStep = pullMode_q ? 3'(pushLen_q) : 3'(pushLen_q - 5'h01);
    // Read data selection
    wire [7:0] rdMux =
        (regAddr == `MIRQ_ADDR_TIMER_COUNT) ? count_q :
        (regAddr == `MIRQ_ADDR_TIMER_CTRL)  ? {tctrl_q[7:4], 1'b0, tctrl_q[2:0]} :
        (regAddr == `MIRQ_ADDR_MISC)        ? {misc_q[7:6], 6'h00} :
        (regAddr == `MIRQ_ADDR_SERIAL_STAT) ? {sstat_q[7:4], 4'h0} :
        (regAddr == `MIRQ_ADDR_CORE_STAT)   ? {coreMask_q, seqBusy_q, pinBLevel_q, pinALevel_q,
                                               1'b0, 3'(src_q)} : 8'h00;

    // Pin synchronisers and edge history
    always_ff @(posedge sys_clk)
    begin
        pinASync_q <= {pinASync_q[0], extIrqPinA_n};
        pinBSync_q <= {pinBSync_q[0], extIrqPinB_n};
        tmrSync_q  <= {tmrSync_q[0], timerPin};
        pinAOld_q  <= pinASync_q[1];
        pinBOld_q  <= pinBSync_q[1];
        tmrOld_q   <= tmrSync_q[1];
        pinALevel_q <= pinASync_q[1];
        pinBLevel_q <= pinBSync_q[1];
    end

    // Miscellaneous register: flag set wins over clear, write of one ignored
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            misc_q <= `MIRQ_MISC_RESET;
        else
        begin
            if (wrMisc)
                misc_q <= {misc_q[7] & regWrData[7], regWrData[6], 6'h00};
            if (fallB)
                misc_q[`MIRQ_BIT_REQ] <= 1'b1;
        end
    end

    // Timer control register
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            tctrl_q <= `MIRQ_TCTRL_RESET;
        else
        begin
            if (wrTctrl)
                tctrl_q <= {tctrl_q[7] & regWrData[7], regWrData[6:4], 1'b0, regWrData[2:0]};
            if (timerZero)
                tctrl_q[`MIRQ_BIT_REQ] <= 1'b1;
        end
    end

    // Serial status request and mask bits
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            sstat_q <= `MIRQ_SSTAT_RESET;
        else
        begin
            if (wrSstat)
                sstat_q <= {sstat_q[7:6] & regWrData[7:6], regWrData[5:4], 4'h0};
            if (serialDone)
                sstat_q[`MIRQ_BIT_SER_REQ] <= 1'b1;
            if (secondTimerTick)
                sstat_q[`MIRQ_BIT_T2_REQ] <= 1'b1;
        end
    end

    // E clock divider, prescaler and down counter
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            eDiv_q  <= 2'h0;
            presc_q <= `MIRQ_PRESC_RESET;
            count_q <= `MIRQ_TIMER_RESET;
        end
        else
        begin
            eDiv_q <= eDiv_q + 2'h1;
            if (prescInit)
                presc_q <= `MIRQ_PRESC_RESET;
            else if (tmrClk)
                presc_q <= presc_q - 7'h01;
            if (wrCount)
                count_q <= regWrData;
            else if (countTick)
                count_q <= countNext;
        end
    end

    // Pin A request latch, cleared on vectoring to its routine
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            reqA_q <= 1'b0;
        else if (fallA)
            reqA_q <= 1'b1;
        else if (vectorLoad_q && src_q == mirq_pkg::SRC_EXTA)
            reqA_q <= 1'b0;
    end

    // Core mask flag with one-instruction delay after clear
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            coreMask_q    <= 1'b1;
            coreMaskEff_q <= 1'b1;
            maskDelay_q   <= 1'b0;
        end
        else
        begin
            if (seq_q == mirq_pkg::SEQ_VECT || setMaskInstr)
                coreMask_q <= 1'b1;
            else if (seq_q == mirq_pkg::SEQ_PULL && stepCnt_q == 3'h0 && pushLen_q == 5'h05)
                coreMask_q <= saveCc_q[3];
            else if (clearMaskInstr)
                coreMask_q <= 1'b0;
            if (clearMaskInstr)
                maskDelay_q <= 1'b1;
            else if (coreBoundary)
                maskDelay_q <= 1'b0;
            if (coreMask_q)
                coreMaskEff_q <= 1'b1;
            else if (!maskDelay_q || coreBoundary)
                coreMaskEff_q <= 1'b0;
        end
    end

    // Stacking sequencer
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            seq_q        <= mirq_pkg::SEQ_VECT;
            src_q        <= mirq_pkg::SRC_RESET;
            sp_q         <= `MIRQ_SP_TOP;
            stepCnt_q    <= 3'h0;
            pullMode_q   <= 1'b0;
            pushLen_q    <= 5'h05;
            reqSoft_q    <= 1'b0;
            savePc_q     <= 14'h0000;
            saveX_q      <= 8'h00;
            saveA_q      <= 8'h00;
            saveCc_q     <= 5'h00;
            stackWrite_q <= 1'b0;
            stackRead_q  <= 1'b0;
            stackAddr_q  <= 14'h0000;
            stackWrData_q <= 8'h00;
            vectorLoad_q <= 1'b0;
            vectorAddr_q <= `MIRQ_VEC_RESET;
        end
        else
        begin
            stackWrite_q <= 1'b0;
            stackRead_q  <= 1'b0;
            vectorLoad_q <= 1'b0;
            if (softIrqInstr)
                reqSoft_q <= 1'b1;
            case (seq_q)
                mirq_pkg::SEQ_IDLE:
                begin
                    if (stackResetInstr)
                        sp_q <= `MIRQ_SP_TOP;
                    if (coreBoundary && anyReq)
                    begin
                        seq_q     <= mirq_pkg::SEQ_PUSH;
                        src_q     <= pick;
                        pushLen_q <= 5'h05;
                        stepCnt_q <= 3'h0;
                        pullMode_q <= 1'b0;
                        savePc_q  <= corePc;
                        saveX_q   <= coreIndex;
                        saveA_q   <= coreAcc;
                        saveCc_q  <= coreCodes;
                    end
                    else if (subCallInstr)
                    begin
                        seq_q     <= mirq_pkg::SEQ_PUSH;
                        src_q     <= mirq_pkg::SRC_NONE;
                        pushLen_q <= 5'h02;
                        stepCnt_q <= 3'h0;
                        pullMode_q <= 1'b0;
                        savePc_q  <= corePc;
                    end
                    else if (irqReturnInstr || subReturnInstr)
                    begin
                        seq_q     <= mirq_pkg::SEQ_PULL;
                        pushLen_q <= irqReturnInstr ? 5'h05 : 5'h02;
                        stepCnt_q <= 3'h0;
                        pullMode_q <= 1'b1;
                    end
                end
                mirq_pkg::SEQ_PUSH:
                begin
                    stackWrite_q  <= 1'b1;
                    stackAddr_q   <= sp_q;
                    stackWrData_q <= pushByte;
                    sp_q          <= spDown;
                    stepCnt_q     <= stepCnt_q + 3'h1;
                    if (stepCnt_q == lastStep)
                        seq_q <= (src_q == mirq_pkg::SRC_NONE) ? mirq_pkg::SEQ_IDLE
                                                               : mirq_pkg::SEQ_VECT;
                end
                mirq_pkg::SEQ_VECT:
                begin
                    vectorLoad_q <= 1'b1;
                    vectorAddr_q <= pickVec;
                    if (src_q == mirq_pkg::SRC_SOFT)
                        reqSoft_q <= 1'b0;
                    if (src_q == mirq_pkg::SRC_RESET)
                        sp_q <= `MIRQ_SP_TOP;
                    seq_q <= mirq_pkg::SEQ_IDLE;
                end
                mirq_pkg::SEQ_PULL:
                begin
                    stackRead_q <= 1'b1;
                    sp_q        <= spUp;
                    stackAddr_q <= spUp;
                    stepCnt_q   <= stepCnt_q + 3'h1;
                    if (stepCnt_q == lastStep - 3'h1)
                        seq_q <= mirq_pkg::SEQ_IDLE;
                end
                default:
                    seq_q <= mirq_pkg::SEQ_IDLE;
            endcase
        end
    end

    // Registered outputs to core and bus
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            irqPending_q <= 1'b0;
            seqBusy_q    <= 1'b1;
            regRdData_q  <= 8'h00;
        end
        else
        begin
            irqPending_q <= anyReq;
            seqBusy_q    <= (seq_q != mirq_pkg::SEQ_IDLE);
            regRdData_q  <= regRdStb ? rdMux : 8'h00;
        end
    end
endmodule : mirq_request_logic
`default_nettype wire

// >>> verif/mirq_request_checker.sv
// Port assertions of the interrupt request logic
`include "mirq_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module mirq_request_checker (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // Pin and core side
    input wire logic        extIrqPinA_n,
    input wire logic        coreBoundary,
    input wire logic [13:0] corePc,
    // Watched outputs
    input wire logic        irqPending_q,
    input wire logic        vectorLoad_q,
    input wire logic [13:0] vectorAddr_q,
    input wire logic        stackWrite_q,
    input wire logic        stackRead_q,
    input wire logic [13:0] stackAddr_q,
    input wire logic [7:0]  stackWrData_q,
    input wire logic        coreMask_q,
    input wire logic        seqBusy_q,
    input wire logic        pinALevel_q
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // Stacking walk and its first two bytes
    sequence pushThenVec;
        stackWrite_q [*5] ##1 vectorLoad_q;
    endsequence
    sequence pcBytes;
        stackWrData_q == $past(corePc[7:0], 2) ##1 stackWrData_q == {2'h0, $past(corePc[13:8], 3)};
    endsequence
    accept_walk_a: assert property (coreBoundary && irqPending_q && !seqBusy_q |=> ##1 pushThenVec)
        else $error("accepted request did not stack five bytes then vector");
    push_pc_a: assert property ($rose(stackWrite_q) |-> pcBytes)
        else $error("stacking did not start with the program counter");
    push_down_a: assert property (stackWrite_q && $past(stackWrite_q) |->
        stackAddr_q == ($past(stackAddr_q) == `MIRQ_SP_LIMIT ? `MIRQ_SP_TOP : $past(stackAddr_q) - 14'h1))
        else $error("stack address did not step down");
    pull_up_a: assert property (stackRead_q && $past(stackRead_q) |->
        stackAddr_q == ($past(stackAddr_q) == `MIRQ_SP_TOP ? `MIRQ_SP_LIMIT : $past(stackAddr_q) + 14'h1))
        else $error("stack address did not step up");
    mask_vec_a: assert property (vectorLoad_q |=> coreMask_q)
        else $error("mask flag not set after vector");
    vec_table_a: assert property (vectorLoad_q |-> vectorAddr_q inside {`MIRQ_VEC_RESET,
        `MIRQ_VEC_SOFT, `MIRQ_VEC_EXTA, `MIRQ_VEC_TIMER, `MIRQ_VEC_SERIAL}) else $error("vector outside table");
    vec_pushed_a: assert property (vectorLoad_q && vectorAddr_q != `MIRQ_VEC_RESET |-> $past(stackWrite_q))
        else $error("vector loaded without stacking");
    pin_level_a: assert property ((!extIrqPinA_n) [*5] |-> !pinALevel_q)
        else $error("pin level not reported low");
endmodule : mirq_request_checker
bind mirq_request_logic mirq_request_checker chk (.sys_clk, .reset, .extIrqPinA_n, .coreBoundary, .corePc,
    .irqPending_q, .vectorLoad_q, .vectorAddr_q, .stackWrite_q, .stackRead_q, .stackAddr_q, .stackWrData_q,
    .coreMask_q, .seqBusy_q, .pinALevel_q);
`default_nettype wire

// >>> verif/mirq_core_model.sv
// Behavioural model of the core sequencer facing the request logic
`timescale 1ns/1ns
`default_nettype none
module mirq_core_model (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Sequencer status
    input  wire logic        seqBusy_q,
    input  wire logic        coreMask_q,
    // Core state and strobes
    output var  logic        coreBoundary,
    output var  logic [6:0]  instr,
    output var  logic [13:0] corePc,
    output wire logic [7:0]  coreIndex,
    output wire logic [7:0]  coreAcc,
    output wire logic [4:0]  coreCodes
);
    // Register images follow the program counter; bit 3 carries the mask flag
    assign coreIndex = corePc[7:0] ^ 8'h5a;
    assign coreAcc   = corePc[7:0] ^ 8'ha5;
    assign coreCodes = {1'b0, coreMask_q, 3'h2};
    initial
    begin
        instr        = 7'h00;
        coreBoundary = 1'b0;
        corePc       = 14'h1000;
    end
    // Boundary every other cycle while the sequencer is free, program moves on
    always @(posedge sys_clk)
    begin
        coreBoundary <= !reset && !coreBoundary && !seqBusy_q;
        corePc       <= reset ? 14'h1000 : corePc + {13'h0, coreBoundary};
    end
    // One-cycle strobe of instruction k
    task automatic run(input int k);
        @(posedge sys_clk);
        instr <= 7'h01 << k;
        @(posedge sys_clk);
        instr <= 7'h00;
    endtask : run
endmodule : mirq_core_model
`default_nettype wire

// >>> verif/tb_mirq_request_logic.sv
// Self-checking bench of the interrupt and timer request logic
`include "mirq_consts.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin miscompares++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module tb_mirq_request_logic;
    logic        sys_clk = 1'b0, reset = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0, timerPin = 1'b0;
    logic        extIrqPinA_n = 1'b1, extIrqPinB_n = 1'b1, serialDone = 1'b0, secondTimerTick = 1'b0;
    logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, rv, regRdData_q, stackWrData_q, coreIndex, coreAcc;
    logic [13:0] vectorAddr_q, stackAddr_q, corePc, pushTop;
    logic [6:0]  instr;
    logic [4:0]  coreCodes;
    logic        irqPending_q, vectorLoad_q, stackWrite_q, stackRead_q, coreMask_q, seqBusy_q;
    logic        pinALevel_q, pinBLevel_q, coreBoundary, wasW = 1'b0;
    int          miscompares = 0, cmp_count = 0;
    mirq_request_logic dut (.sys_clk, .reset, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData_q,
        .extIrqPinA_n, .extIrqPinB_n, .timerPin, .serialDone, .secondTimerTick, .coreBoundary,
        .softIrqInstr(instr[0]), .irqReturnInstr(instr[1]), .clearMaskInstr(instr[2]), .setMaskInstr(instr[3]),
        .stackResetInstr(instr[4]), .subCallInstr(instr[5]), .subReturnInstr(instr[6]), .corePc, .coreIndex,
        .coreAcc, .coreCodes, .irqPending_q, .vectorLoad_q, .vectorAddr_q, .stackWrite_q, .stackRead_q,
        .stackAddr_q, .stackWrData_q, .coreMask_q, .seqBusy_q, .pinALevel_q, .pinBLevel_q);
    mirq_core_model core (.sys_clk, .reset, .seqBusy_q, .coreMask_q, .coreBoundary, .instr, .corePc,
        .coreIndex, .coreAcc, .coreCodes);
    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end
    // Address of the first push of each stacking run
    always @(posedge sys_clk)
    begin
        wasW <= stackWrite_q;
        if (stackWrite_q && !wasW) pushTop <= stackAddr_q;
    end
    // One register cycle; read data lands in rv
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= w;
        regRdStb  <= !w;
        @(posedge sys_clk);
        regWrStb  <= 1'b0;
        regRdStb  <= 1'b0;
        #1 rv = regRdData_q;
    endtask : acc
    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        `CHK(n, e, rv)
    endtask : rc
    // Bounded wait for a vector load, then the mask flag
    task automatic wait_vec(input logic [13:0] e);
        int k = 0;
        while (vectorLoad_q !== 1'b1 && k < 400)
        begin
            @(posedge sys_clk);
            #1 k++;
        end
        if (k == 400) miscompares++;
        if (k == 400) end_of_test();
        `CHK("vector", e, vectorAddr_q)
        @(posedge sys_clk);
        #1 `CHK("mask flag", 1'b1, coreMask_q)
    endtask : wait_vec
    // Return instruction; five pulls fit in the wait
    task automatic ret;
        core.run(1);
        repeat (10) @(posedge sys_clk);
    endtask : ret
    task automatic pins(input logic a, input logic b);
        @(posedge sys_clk);
        extIrqPinA_n <= a;
        extIrqPinB_n <= b;
        repeat (6) @(posedge sys_clk);
    endtask : pins
    task automatic pulse(input logic s);
        @(posedge sys_clk);
        serialDone      <= s;
        secondTimerTick <= !s;
        @(posedge sys_clk);
        serialDone      <= 1'b0;
        secondTimerTick <= 1'b0;
    endtask : pulse
    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // Main sequence
    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        #1 wait_vec(`MIRQ_VEC_RESET);
        rc("misc", `MIRQ_ADDR_MISC, `MIRQ_MISC_RESET);
        rc("timer ctrl", `MIRQ_ADDR_TIMER_CTRL, 8'h50);
        rc("serial stat", `MIRQ_ADDR_SERIAL_STAT, 8'h30);
        rc("count", `MIRQ_ADDR_TIMER_COUNT, 8'hff);
        rc("unmapped", 8'h3f, 8'h00);
        acc(1'b1, `MIRQ_ADDR_MISC, 8'hc0);
        rc("misc", `MIRQ_ADDR_MISC, 8'h40);
        acc(1'b1, `MIRQ_ADDR_MISC, 8'h00);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
        rc("misc", `MIRQ_ADDR_MISC, 8'h80);
        `CHK("pending", 1'b0, irqPending_q)
        core.run(2);
        wait_vec(`MIRQ_VEC_EXTA);
        ret;
        wait_vec(`MIRQ_VEC_TIMER);
        acc(1'b1, `MIRQ_ADDR_MISC, 8'h40);
        ret;
        rc("misc", `MIRQ_ADDR_MISC, 8'h40);
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
        rc("misc", `MIRQ_ADDR_MISC, 8'hc0);
        `CHK("pending", 1'b0, irqPending_q)
        acc(1'b1, `MIRQ_ADDR_SERIAL_STAT, 8'h00);
        pulse(1'b1);
        wait_vec(`MIRQ_VEC_SERIAL);
        rc("serial stat", `MIRQ_ADDR_SERIAL_STAT, 8'h80);
        acc(1'b1, `MIRQ_ADDR_SERIAL_STAT, 8'h10);
        ret;
        pulse(1'b0);
        rc("serial stat", `MIRQ_ADDR_SERIAL_STAT, 8'h50);
        `CHK("pending", 1'b0, irqPending_q)
        acc(1'b1, `MIRQ_ADDR_TIMER_COUNT, 8'h03);
        acc(1'b1, `MIRQ_ADDR_TIMER_CTRL, 8'h00);
        wait_vec(`MIRQ_VEC_TIMER);
        rc("timer ctrl", `MIRQ_ADDR_TIMER_CTRL, 8'h80);
        acc(1'b0, `MIRQ_ADDR_TIMER_COUNT, 8'h00);
        `CHK("count top", 4'hf, rv[7:4])
        acc(1'b1, `MIRQ_ADDR_TIMER_CTRL, 8'h80);
        rc("timer ctrl", `MIRQ_ADDR_TIMER_CTRL, 8'h80);
        acc(1'b1, `MIRQ_ADDR_TIMER_CTRL, 8'h68);
        rc("timer ctrl", `MIRQ_ADDR_TIMER_CTRL, 8'h60);
        acc(1'b0, `MIRQ_ADDR_TIMER_COUNT, 8'h00);
        rc("count", `MIRQ_ADDR_TIMER_COUNT, rv);
        // Event source: two falling edges on the timer pin count down to zero
        acc(1'b1, `MIRQ_ADDR_TIMER_COUNT, 8'h02);
        acc(1'b1, `MIRQ_ADDR_TIMER_CTRL, 8'h70);
        repeat (2)
        begin
            @(posedge sys_clk);
            timerPin <= 1'b1;
            repeat (4) @(posedge sys_clk);
            timerPin <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        rc("timer ctrl", `MIRQ_ADDR_TIMER_CTRL, 8'hf0);
        rc("count", `MIRQ_ADDR_TIMER_COUNT, 8'h00);
        ret;
        core.run(5);
        repeat (4) @(posedge sys_clk);
        core.run(4);
        core.run(3);
        core.run(0);
        wait_vec(`MIRQ_VEC_SOFT);
        `CHK("stack top", `MIRQ_SP_TOP, pushTop)
        ret;
        #1 `CHK("mask flag", 1'b1, coreMask_q)
        // Subroutine return must leave the mask flag alone
        core.run(2);
        core.run(6);
        repeat (6) @(posedge sys_clk);
        #1 `CHK("mask flag", 1'b0, coreMask_q)
        end_of_test();
    end
endmodule : tb_mirq_request_logic
`default_nettype wire
